// [hw/rsc_combiner.sv]
// Purpose: merge reset sources, record cause flags, hold watchdog/sleep controls
// Assumes: sources are asynchronous levels; core events are one-cycle pulses
// Notes:   flags survive every reset except power-on; AHB-Lite slave, zero wait
//
// Overview of operation
// - any active source asserts the single master system reset output
// - nine reset causes are inputs, all feeding the master reset
// - each reset kind sets a flag in the status register; illegal opcode and uninitialized pointer share bit 14
// - power-on clears all status bits except brown-out and power-on, which set
// - software may set or clear flags anytime; setting never causes a reset
// - defined-state registers reset on SRST; others keep through non-POR resets
// - bit 15 set on trap conflict, cleared by power-on or software
// - bit 14 set on illegal opcode or uninitialized pointer
// - bit 9 set on configuration mismatch reset, cleared by power-on
// - bit 7 set on external pin reset, cleared by power-on
// - bit 6 set on reset instruction, cleared by power-on
// - bit 4 set on watchdog time-out, cleared by power-save or power-on
// - bit 3 set when power-save enters sleep, cleared by power-on
// - bit 2 set when power-save enters idle, cleared by power-on
// - bit 1 set on brown-out and power-on; hardware never clears it
// - bit 0 set on power-on; only software clears it
// - bit 5 enables watchdog; fuse at one forces it enabled
// - bit 8 keeps program memory bias powered in sleep, else regulator standby
// - bits 13 to 10 read zero and ignore writes
`timescale 1ns/10ps
module rsc_combiner
   import rsc_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input  wire logic                CLOCK,
   input  wire logic                SRST,
   // reset sources and core events
   input  wire rsc_pkg::rsc_src_t   RESET_SOURCES,
   input  wire rsc_pkg::rsc_psave_t POWER_SAVE_INSTRUCTION,
   input  wire logic                FUSE_WATCHDOG_ENABLE,
   // ahb-lite slave
   input  wire logic                HSEL,
   input  wire logic [31:0]         HADDR,
   input  wire logic [1:0]          HTRANS,
   input  wire logic                HWRITE,
   input  wire logic [2:0]          HSIZE,
   input  wire logic                HREADY,
   input  wire logic [31:0]         HWDATA,
   output logic      [31:0]         HRDATA,
   output logic                     HREADYOUT,
   output logic      [1:0]          HRESP,
   // system outputs
   output logic                     MASTER_SYSTEM_RESET,
   output logic                     WATCHDOG_ENABLE,
   output logic                     PROGMEM_SLEEP_POWER,
   output logic                     REGULATOR_STANDBY
);
   import rsc_pkg::*;

   initial
   begin
      if (ADDR_W < 3 || ADDR_W > 32)
         $error("rsc_combiner: ADDR_W out of range");
   end

   // source synchronisation
   rsc_src_t src_sync;
   logic     fuse_sync;

   rsc_sync #(.WIDTH($bits(rsc_src_t) + 1)) u_sync (
      .clk (CLOCK),
      .d   ({RESET_SOURCES, FUSE_WATCHDOG_ENABLE}),
      .q   ({src_sync, fuse_sync})
   );

   // state
   logic [15:0]       cause_ff,    nxt_cause;
   logic              msr_ff,      nxt_msr;
   logic              wdog_ff,     nxt_wdog;
   logic              pmpwr_ff,    nxt_pmpwr;
   logic              stby_ff,     nxt_stby;
   logic              wr_pend_ff,  nxt_wr_pend;
   logic [ADDR_W-1:0] addr_ff,     nxt_addr;
   logic [31:0]       rdata_ff,    nxt_rdata;
   logic              rd_pend;

   // decode helper used for both read and write phases
   function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
      logic [ADDR_W-1:0] o;
      o       = ADDR_W'(ofs);
      addr_is = (a[ADDR_W-1:2] == o[ADDR_W-1:2]);
   endfunction : addr_is

   logic addr_phase;
   assign addr_phase = HSEL && HREADY && (HTRANS == RSC_HTRANS_NSEQ);

   // bus pipeline and read data
   always_comb
   begin
      nxt_wr_pend = addr_phase && HWRITE;
      nxt_addr    = addr_phase ? HADDR[ADDR_W-1:0] : addr_ff;
      rd_pend     = addr_phase && !HWRITE;
      nxt_rdata   = 32'h0000_0000;
      if (rd_pend && addr_is(HADDR[ADDR_W-1:0], RSC_CAUSE_OFS))
         nxt_rdata = {16'h0000, cause_ff & RSC_IMPL_MASK};
      else if (rd_pend && addr_is(HADDR[ADDR_W-1:0], RSC_SOURCE_OFS))
         nxt_rdata = {23'h000000, src_sync};
   end

   // status register next value
   always_comb
   begin
      nxt_cause = cause_ff;
      if (wr_pend_ff && addr_is(addr_ff, RSC_CAUSE_OFS))
         nxt_cause = HWDATA[15:0] & RSC_IMPL_MASK;
      if (POWER_SAVE_INSTRUCTION.enter_sleep || POWER_SAVE_INSTRUCTION.enter_idle)
         nxt_cause[RSC_B_WDOG] = 1'b0;
      // hardware sets applied last so they win
      if (src_sync.trap_conflict)
         nxt_cause[RSC_B_TRAP] = 1'b1;
      if (src_sync.illegal_opcode || src_sync.uninit_pointer)
         nxt_cause[RSC_B_IOPU] = 1'b1;
      if (src_sync.config_mismatch)
         nxt_cause[RSC_B_MISMATCH] = 1'b1;
      if (src_sync.external_pin)
         nxt_cause[RSC_B_PIN] = 1'b1;
      if (src_sync.instruction)
         nxt_cause[RSC_B_INSTR] = 1'b1;
      if (src_sync.watchdog)
         nxt_cause[RSC_B_WDOG] = 1'b1;
      if (POWER_SAVE_INSTRUCTION.enter_sleep)
         nxt_cause[RSC_B_SLEEP] = 1'b1;
      if (POWER_SAVE_INSTRUCTION.enter_idle)
         nxt_cause[RSC_B_IDLE] = 1'b1;
      if (src_sync.brown_out)
         nxt_cause[RSC_B_BROWN] = 1'b1;
      // power-on clears all but sets the two low bits
      if (src_sync.power_on)
         nxt_cause = RSC_POR_VALUE;
   end

   // outputs derived from state
   always_comb
   begin
      nxt_msr   = |src_sync;
      nxt_wdog  = fuse_sync || nxt_cause[RSC_B_WDEN];
      // bias and regulator follow the sleep power bit
      nxt_pmpwr = nxt_cause[RSC_B_PMPWR];
      nxt_stby  = !nxt_cause[RSC_B_PMPWR];
   end

   // flags not touched by SRST: only power-on redefines them
   always_ff @(posedge CLOCK)
   begin
      // unimplemented bits held at zero even before power-on
      cause_ff <= nxt_cause & RSC_IMPL_MASK;
   end

   // controls with a defined reset state
   always_ff @(posedge CLOCK)
   begin
      if (SRST)
      begin
         msr_ff     <= 1'b1;
         wdog_ff    <= 1'b0;
         pmpwr_ff   <= 1'b0;
         stby_ff    <= 1'b1;
         wr_pend_ff <= 1'b0;
         addr_ff    <= '0;
         rdata_ff   <= 32'h0000_0000;
      end
      else
      begin
         msr_ff     <= nxt_msr;
         wdog_ff    <= nxt_wdog;
         pmpwr_ff   <= nxt_pmpwr;
         stby_ff    <= nxt_stby;
         wr_pend_ff <= nxt_wr_pend;
         addr_ff    <= nxt_addr;
         rdata_ff   <= nxt_rdata;
      end
   end

   assign MASTER_SYSTEM_RESET = msr_ff;
   assign WATCHDOG_ENABLE     = wdog_ff;
   assign PROGMEM_SLEEP_POWER = pmpwr_ff;
   assign REGULATOR_STANDBY   = stby_ff;
   assign HRDATA              = rdata_ff;
   // zero wait states, always okay
   assign HREADYOUT           = 1'b1;
   assign HRESP               = RSC_HRESP_OKAY;

   // assertions
   sequence s_por_seen;
      src_sync.power_on;
   endsequence

   // power-on gives exact value
   a_por_value: assert property (@(posedge CLOCK)
      s_por_seen |=> (cause_ff == RSC_POR_VALUE))
      else $error("power-on did not leave value 0003");

   a_master_reset: assert property (@(posedge CLOCK) disable iff (SRST)
      (|src_sync) |=> MASTER_SYSTEM_RESET)
      else $error("active source without master reset");

   a_master_release: assert property (@(posedge CLOCK) disable iff (SRST)
      (src_sync == '0) |=> !MASTER_SYSTEM_RESET)
      else $error("master reset without any source");

   a_trap_flag: assert property (@(posedge CLOCK)
      (src_sync.trap_conflict && !src_sync.power_on) |=> cause_ff[RSC_B_TRAP])
      else $error("trap flag not set");

   a_iopu_flag: assert property (@(posedge CLOCK)
      ((src_sync.illegal_opcode || src_sync.uninit_pointer) && !src_sync.power_on)
      |=> cause_ff[RSC_B_IOPU])
      else $error("opcode flag not set");

   a_mismatch_flag: assert property (@(posedge CLOCK)
      (src_sync.config_mismatch && !src_sync.power_on) |=> cause_ff[RSC_B_MISMATCH])
      else $error("mismatch flag not set");

   a_pin_flag: assert property (@(posedge CLOCK)
      (src_sync.external_pin && !src_sync.power_on) |=> cause_ff[RSC_B_PIN])
      else $error("pin flag not set");

   a_instr_flag: assert property (@(posedge CLOCK)
      (src_sync.instruction && !src_sync.power_on) |=> cause_ff[RSC_B_INSTR])
      else $error("instruction flag not set");

   a_wdog_clear: assert property (@(posedge CLOCK)
      ((POWER_SAVE_INSTRUCTION.enter_sleep || POWER_SAVE_INSTRUCTION.enter_idle)
       && !src_sync.watchdog) |=> !cause_ff[RSC_B_WDOG])
      else $error("power-save left watchdog flag set");

   a_sleep_flag: assert property (@(posedge CLOCK)
      (POWER_SAVE_INSTRUCTION.enter_sleep && !src_sync.power_on) |=> cause_ff[RSC_B_SLEEP])
      else $error("sleep flag not set");

   a_idle_flag: assert property (@(posedge CLOCK)
      (POWER_SAVE_INSTRUCTION.enter_idle && !src_sync.power_on) |=> cause_ff[RSC_B_IDLE])
      else $error("idle flag not set");

   a_brown_flag: assert property (@(posedge CLOCK)
      src_sync.brown_out |=> cause_ff[RSC_B_BROWN])
      else $error("brown-out flag not set");

   a_unimpl_zero: assert property (@(posedge CLOCK) disable iff (SRST)
      cause_ff[13:10] == 4'h0)
      else $error("unimplemented bits not zero");

   a_wdog_fuse: assert property (@(posedge CLOCK) disable iff (SRST)
      fuse_sync |=> WATCHDOG_ENABLE)
      else $error("fuse did not force watchdog on");

   a_pmpwr_pair: assert property (@(posedge CLOCK) disable iff (SRST)
      PROGMEM_SLEEP_POWER != REGULATOR_STANDBY)
      else $error("sleep power and standby agree");

   a_set_wins: assert property (@(posedge CLOCK)
      (wr_pend_ff && addr_is(addr_ff, RSC_CAUSE_OFS) && POWER_SAVE_INSTRUCTION.enter_idle
       && !src_sync.power_on) |=> cause_ff[RSC_B_IDLE])
      else $error("software write beat hardware set");

   a_sw_noreset: assert property (@(posedge CLOCK) disable iff (SRST)
      (wr_pend_ff && src_sync == '0) ##1 (src_sync == '0) |=> !MASTER_SYSTEM_RESET)
      else $error("software write caused reset");

endmodule : rsc_combiner

// [hw/rsc_pkg.sv]
// Purpose: shared constants and carriers for the reset source combiner
// Assumes: one 100 MHz clock, AHB-Lite register access, 32-bit data
// Notes:   the status register sits in the low half of one bus word
package rsc_pkg;

   // register map (byte addresses)
   localparam logic [11:0] RSC_CAUSE_OFS   = 12'h000;  // reset_cause_control
   localparam logic [11:0] RSC_SOURCE_OFS  = 12'h004;  // live source levels, read only

   // field positions in reset_cause_control
   localparam int RSC_B_POR      = 0;
   localparam int RSC_B_BROWN    = 1;
   localparam int RSC_B_IDLE     = 2;
   localparam int RSC_B_SLEEP    = 3;
   localparam int RSC_B_WDOG     = 4;
   localparam int RSC_B_WDEN     = 5;
   localparam int RSC_B_INSTR    = 6;
   localparam int RSC_B_PIN      = 7;
   localparam int RSC_B_PMPWR    = 8;
   localparam int RSC_B_MISMATCH = 9;
   localparam int RSC_B_IOPU   = 14;
   localparam int RSC_B_TRAP   = 15;

   // writable bits; 13..10 are unimplemented
   localparam logic [15:0] RSC_IMPL_MASK   = 16'hC3FF;
   // value left by a power-on reset
   localparam logic [15:0] RSC_POR_VALUE   = 16'h0003;
   localparam logic [1:0]  RSC_HRESP_OKAY  = 2'h0;
   localparam logic [1:0]  RSC_HTRANS_NSEQ = 2'h2;

   // reset sources as one carrier
   typedef struct packed {
      logic power_on;
      logic brown_out;
      logic external_pin;
      logic instruction;
      logic watchdog;
      logic config_mismatch;
      logic trap_conflict;
      logic illegal_opcode;
      logic uninit_pointer;
   } rsc_src_t;

   // power-save events from the core
   typedef struct packed {
      logic enter_sleep;
      logic enter_idle;
   } rsc_psave_t;

endpackage : rsc_pkg

// [hw/rsc_sync.sv]
// Purpose: two-flop synchroniser for a vector of asynchronous levels
// Assumes: inputs are levels that stay for several clocks
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module rsc_sync #(
   parameter int WIDTH = 9
) (
   // clock
   input  wire logic             clk,
   // data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] q_ff;

   initial
   begin
      if (WIDTH < 1)
         $error("rsc_sync: WIDTH must be at least 1");
   end

   // no reset: synchroniser must pass a source that is active during reset
   always_ff @(posedge clk)
   begin
      meta_ff <= d;
      q_ff    <= meta_ff;
   end

   assign q = q_ff;
endmodule : rsc_sync

// [tb/rsc_src_model.sv]
// Purpose: behavioural reset sources and core power-save events
// Assumes: sources are levels held for several clocks
// Notes:   the bench calls the tasks by hierarchical name
`timescale 1ns/10ps
module rsc_src_model (
   // clock
   input  wire logic           clk,
   // towards the combiner
   output rsc_pkg::rsc_src_t   src,
   output rsc_pkg::rsc_psave_t psave
);
   import rsc_pkg::*;

   logic [8:0] lvl_ff;
   logic [1:0] ps_ff;

   // power-on active from time zero, so the flags are defined before srst ends
   initial
   begin
      lvl_ff = 9'h100;
      ps_ff  = 2'h0;
   end

   assign src   = rsc_src_t'(lvl_ff);
   assign psave = rsc_psave_t'(ps_ff);

   // one source as a level; short holds still clear the synchroniser
   task automatic raise(input int idx, input int len);
      begin
         @(posedge clk);
         lvl_ff[idx] <= 1'b1;
         repeat (len) @(posedge clk);
         lvl_ff[idx] <= 1'b0;
      end
   endtask : raise

   // one-cycle power-save pulse on the combiner clock
   task automatic save(input int which);
      begin
         @(posedge clk);
         ps_ff[which] <= 1'b1;
         @(posedge clk);
         ps_ff[which] <= 1'b0;
      end
   endtask : save
endmodule : rsc_src_model

// [tb/tb_reset_source_combiner_flags.sv]
// Purpose: self-checking bench for the reset source combiner
// Assumes: one ahb-lite master, one slave, zero-wait answers allowed
// Notes:   status register is defined only after a power-on event
`timescale 1ns/10ps
module tb_reset_source_combiner_flags;
   import rsc_pkg::*;

   localparam logic [31:0] CAUSE_A = {20'h00000, RSC_CAUSE_OFS};

   logic        clock;
   logic        srst;
   logic        fuse;
   logic        hsel;
   logic        hwrite;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic [1:0]  hresp;
   logic        msr;
   logic        wde;
   logic        pmp;
   logic        rstb;
   rsc_src_t    src;
   rsc_psave_t  psv;
   int          err_count;
   int          cmp_count;
   logic [31:0] rd;
   int          idx_t [8] = '{7, 6, 5, 4, 3, 2, 1, 0};
   logic [15:0] bit_t [8] = '{16'h0002, 16'h0080, 16'h0040, 16'h0010,
                              16'h0200, 16'h8000, 16'h4000, 16'h4000};

   // free-running 100 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   rsc_src_model src_u (.clk(clock), .src(src), .psave(psv));

   rsc_combiner dut_u (
      .CLOCK(clock), .SRST(srst), .RESET_SOURCES(src),
      .POWER_SAVE_INSTRUCTION(psv), .FUSE_WATCHDOG_ENABLE(fuse),
      .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(hsize), .HREADY(hreadyout), .HWDATA(hwdata), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .MASTER_SYSTEM_RESET(msr),
      .WATCHDOG_ENABLE(wde), .PROGMEM_SLEEP_POWER(pmp), .REGULATOR_STANDBY(rstb)
   );

   // compare and count
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      begin
         cmp_count++;
         if (seen !== exp)
         begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask : chk

   // only the watchdog ends a stuck wait
   task automatic wait_rdy;
      begin
         @(posedge clock);
         while (hreadyout !== 1'b1)
            @(posedge clock);
      end
   endtask : wait_rdy

   // one single word transfer; read data taken at the data-phase edge
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      begin
         @(posedge clock);
         hsel   <= 1'b1;
         haddr  <= a;
         hwrite <= wr;
         htrans <= RSC_HTRANS_NSEQ;
         wait_rdy();
         hsel   <= 1'b0;
         htrans <= 2'h0;
         hwdata <= wr ? d : 32'h0;
         wait_rdy();
         rd = hrdata;
      end
   endtask : ahb

   task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
      begin
         ahb(1'b0, a, 32'h0);
         chk(what, rd, exp);
      end
   endtask : rdchk

   // power-on pulse, then the register must hold only the two low flags
   task automatic por;
      begin
         src_u.raise(8, 5);
         #1;
         chk("msr_por", 32'(msr), 32'h1);
         repeat (4) @(posedge clock);
         chk("msr_free", 32'(msr), 32'h0);
         rdchk("cause_por", CAUSE_A, 32'h3);
      end
   endtask : por

   task automatic tally_and_finish;
      begin
         $display("mismatches %0d compares %0d", err_count, cmp_count);
         if (err_count == 0 && cmp_count > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask : tally_and_finish

   // cut a hang short
   initial
   begin
      repeat (5000) @(posedge clock);
      err_count++;
      tally_and_finish();
   end

   // main sequence
   initial
   begin
      srst = 1'b1;
      fuse = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      err_count = 0;
      cmp_count = 0;
      repeat (4) @(posedge clock);
      chk("msr_srst", 32'(msr), 32'h1);
      srst <= 1'b0;
      por();
      // every non-power cause sets its flag (opcode and pointer share bit 14); sleep bit survives
      for (int i = 0; i < 8; i++)
      begin
         ahb(1'b1, CAUSE_A, 32'h0100); // clear flags before next cause
         src_u.raise(idx_t[i], 4 + i);
         #1;
         chk("msr_src", 32'(msr), 32'h1);
         repeat (4) @(posedge clock);
         chk("msr_gone", 32'(msr), 32'h0);
         rdchk("flag", CAUSE_A, {16'h0, bit_t[i] | 16'h0100});
         chk("pm_bias", {30'h0, pmp, rstb}, 32'h2);
      end
      // software sets all flags without any reset
      ahb(1'b1, CAUSE_A, 32'hFFFF_FFFF);
      repeat (4) @(posedge clock);
      chk("msr_sw", 32'(msr), 32'h0);
      rdchk("all_ones", CAUSE_A, 32'hC3FF);
      chk("standby", {30'h0, pmp, rstb}, 32'h2);
      ahb(1'b1, CAUSE_A, 32'h0010);
      @(posedge clock);
      chk("pm_off", {30'h0, pmp, rstb}, 32'h1);
      // sleep clears the watchdog flag, idle adds its own
      src_u.save(1);
      rdchk("sleep", CAUSE_A, 32'h0008);
      src_u.save(0);
      rdchk("idle", CAUSE_A, 32'h000C);
      // idle event lands on the same edge as a clearing write
      fork
         ahb(1'b1, CAUSE_A, 32'h0);
         begin
            @(posedge clock);
            src_u.save(0);
         end
      join
      rdchk("hw_wins", CAUSE_A, 32'h0004);
      // fuse forces the watchdog on while bit 5 is clear; then bit 5 alone enables it
      @(posedge clock);
      fuse <= 1'b1;
      repeat (5) @(posedge clock);
      chk("wdt_fuse", 32'(wde), 32'h1);
      fuse <= 1'b0;
      repeat (5) @(posedge clock);
      chk("wdt_off", 32'(wde), 32'h0);
      ahb(1'b1, CAUSE_A, 32'h0020);
      repeat (2) @(posedge clock);
      chk("wdt_sw", 32'(wde), 32'h1);
      // unmapped place reads zero and ignores writes
      ahb(1'b1, 32'h8, 32'hFFFF);
      rdchk("unmapped", 32'h8, 32'h0);
      ahb(1'b1, CAUSE_A, 32'hC3FC);
      por();
      tally_and_finish();
   end
endmodule : tb_reset_source_combiner_flags
